// ---- core/queue_ctrl_pkg.sv ----
// Constants shared by the sample queue control logic
package queue_ctrl_pkg;
	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] QUEUE_CONTROL_ADDR  = 8'h2D;
	localparam logic [7:0] WATERMARK_ADDR      = 8'h2E;
	localparam logic [7:0] PENDING_FLAGS_ADDR  = 8'h2F;
	// ------------------------------------------------------------
	// Queue control field positions
	// ------------------------------------------------------------
	localparam int EMPTY_IRQ_ALLOW_BIT     = 0;
	localparam int FULL_IRQ_ALLOW_BIT      = 1;
	localparam int WATERMARK_IRQ_ALLOW_BIT = 2;
	localparam int SINGLE_PIN_ROUTING_BIT  = 3;
	localparam int POINTER_RESET_BIT       = 4;
	localparam int QUEUE_ENABLE_BIT        = 5;
	localparam int WATERMARK_MODE_BIT      = 6;
	localparam int CONTROL_STORED_BITS     = 7;
	// ------------------------------------------------------------
	// Pending flag positions and field widths
	// ------------------------------------------------------------
	localparam int EMPTY_PENDING_BIT       = 0;
	localparam int FULL_PENDING_BIT        = 1;
	localparam int WATERMARK_PENDING_BIT   = 2;
	localparam int PENDING_BITS            = 3;
	localparam int LEVEL_BITS              = 5;
	// ------------------------------------------------------------
	// Reset values and sizes
	// ------------------------------------------------------------
	localparam logic [7:0] QUEUE_CONTROL_RESET = 8'h00;
	localparam logic [4:0] WATERMARK_RESET     = 5'h10;
	localparam int         QUEUE_DEPTH         = 32;
endpackage : queue_ctrl_pkg

// ---- core/accel_sample_fifo_control.sv ----
// Control, watermark and pending-flag logic of the accelerometer sample queue
`timescale 1ns/1ps
// Notes on behaviour
// - Control bit 0 allows empty event, resets 0
// - Control bit 1 allows full event, resets 0
// - Control bit 2 allows watermark event, resets 0
// - Bit 3 routes all requests to primary
// - Bit 4 clears pointers, keeps stored samples
// - Bit 5 enables queue; zero stops push, pop and pending flags
// - Bit 6 drops samples at watermark level
// - Control register powers up as zero
// - Watermark level bits 4:0, reset sixteen
// - Watermark bits 7:5 read as zero
// - Pending flags: empty, full, watermark bits
// - Flag reported only while its allow set
// - Pending bits 7:3 read as zero
// - Queue runs at the decimated sample rate
module accel_sample_fifo_control
	import queue_ctrl_pkg::*;
#(
	parameter int depth = QUEUE_DEPTH
) (
	input  wire logic       sys_clk,        // Block clock, 25 MHz
	input  wire logic       rst,            // Synchronous reset, active high
	input  wire logic [7:0] reg_addr,       // Register address from serial interface
	input  wire logic [7:0] reg_wdata,      // Register write data
	input  wire logic       reg_wr,         // Register write strobe, one cycle
	input  wire logic       reg_rd,         // Register read strobe, one cycle
	output logic      [7:0] reg_rdata,      // Read data, valid the cycle after reg_rd
	input  wire logic       sample_clk,     // Decimated sample clock pin, rising edge = sample
	input  wire logic       sample_pop,     // Host drained one sample, one cycle
	input  wire logic       motion_req,     // Motion and per-sample request level
	output logic            sample_accept,  // One-cycle write strobe to sample storage
	output logic      [4:0] wr_ptr,         // Storage write pointer
	output logic      [4:0] rd_ptr,         // Storage read pointer
	output logic      [5:0] sample_count,   // Samples held
	output logic            irq_out_primary,   // First interrupt output, active high
	output logic            irq_out_secondary  // Second interrupt output, active high
);
	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	// Pointers are five bits and the level cannot name more than 31
	if (depth != QUEUE_DEPTH) begin : g_depth_check
		$error("depth must be 32");
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	logic [CONTROL_STORED_BITS-1:0] queue_control;
	logic [LEVEL_BITS-1:0]          watermark_level;
	logic                           wr_control;
	logic                           pointer_reset;
	logic                           queue_on;
	logic [PENDING_BITS-1:0]        pending;

	assign wr_control = reg_wr && (reg_addr == QUEUE_CONTROL_ADDR);
	assign queue_on   = queue_control[QUEUE_ENABLE_BIT];
	// Pointer reset is a one-cycle action so the host need not clear it again
	assign pointer_reset = queue_control[POINTER_RESET_BIT];

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			queue_control <= QUEUE_CONTROL_RESET[CONTROL_STORED_BITS-1:0];
		end else if (wr_control) begin
			queue_control <= reg_wdata[CONTROL_STORED_BITS-1:0];
		end else begin
			queue_control[POINTER_RESET_BIT] <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			watermark_level <= WATERMARK_RESET;
		end else if (reg_wr && reg_addr == WATERMARK_ADDR) begin
			watermark_level <= reg_wdata[LEVEL_BITS-1:0];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			unique case (reg_addr)
				QUEUE_CONTROL_ADDR: reg_rdata <= {1'b0, queue_control};
				WATERMARK_ADDR:     reg_rdata <= {3'h0, watermark_level};
				PENDING_FLAGS_ADDR: reg_rdata <= {5'h00, pending};
				default:            reg_rdata <= 8'h00;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Sample clock capture
	// ------------------------------------------------------------
	logic sample_meta;
	logic sample_sync;
	logic sample_last;
	logic sample_edge;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sample_meta <= 1'b0;
			sample_sync <= 1'b0;
			sample_last <= 1'b0;
		end else begin
			sample_meta <= sample_clk;
			sample_sync <= sample_meta;
			sample_last <= sample_sync;
		end
	end

	// Samples arrive only at the decimated output rate
	assign sample_edge = sample_sync && !sample_last;

	// ------------------------------------------------------------
	// Queue pointers and count
	// ------------------------------------------------------------
	logic at_level;
	logic queue_full;
	logic queue_empty;
	logic do_push;
	logic do_pop;

	assign at_level    = sample_count >= {1'b0, watermark_level};
	assign queue_full  = sample_count == 6'(depth);
	assign queue_empty = sample_count == 6'h00;
	assign do_push = queue_on && sample_edge && !queue_full
		&& !(queue_control[WATERMARK_MODE_BIT] && at_level);
	assign do_pop  = queue_on && sample_pop && !queue_empty;

	always_ff @(posedge sys_clk) begin
		if (rst || pointer_reset) begin
			wr_ptr       <= 5'h00;
			rd_ptr       <= 5'h00;
			sample_count <= 6'h00;
		end else begin
			if (do_push) begin
				wr_ptr <= wr_ptr + 5'h01;
			end
			if (do_pop) begin
				rd_ptr <= rd_ptr + 5'h01;
			end
			unique case ({do_push, do_pop})
				2'b10:   sample_count <= sample_count + 6'h01;
				2'b01:   sample_count <= sample_count - 6'h01;
				default: sample_count <= sample_count;
			endcase
		end
	end

	// Storage is written outside this block; contents survive a pointer reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			sample_accept <= 1'b0;
		end else begin
			sample_accept <= do_push && !pointer_reset;
		end
	end

	// ------------------------------------------------------------
	// Pending flags and interrupt routing
	// ------------------------------------------------------------
	// Flags are levels of the live condition; nothing sticky to clear
	assign pending[EMPTY_PENDING_BIT] = queue_on
		&& queue_control[EMPTY_IRQ_ALLOW_BIT] && queue_empty;
	assign pending[FULL_PENDING_BIT] = queue_on
		&& queue_control[FULL_IRQ_ALLOW_BIT] && queue_full;
	assign pending[WATERMARK_PENDING_BIT] = queue_on
		&& queue_control[WATERMARK_IRQ_ALLOW_BIT] && at_level;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			irq_out_primary   <= 1'b0;
			irq_out_secondary <= 1'b0;
		end else if (queue_control[SINGLE_PIN_ROUTING_BIT]) begin
			irq_out_primary   <= motion_req || (|pending);
			irq_out_secondary <= 1'b0;
		end else begin
			irq_out_primary   <= motion_req;
			irq_out_secondary <= |pending;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	control_reset_a: assert property ($fell(rst) |-> queue_control == 7'h00)
		else $error("control not zero after reset");
	count_bound_a: assert property (sample_count <= 6'(depth))
		else $error("count above depth");
	disabled_hold_a: assert property (!queue_on && !pointer_reset |=> $stable(sample_count))
		else $error("count moved while disabled");
	drop_level_a: assert property (queue_control[WATERMARK_MODE_BIT] && at_level
		&& !sample_pop |=> sample_count <= $past(sample_count))
		else $error("sample taken at watermark");
	ptr_reset_a: assert property (wr_control && reg_wdata[POINTER_RESET_BIT]
		|=> ##1 wr_ptr == 5'h00 && rd_ptr == 5'h00 && sample_count == 6'h00)
		else $error("pointer reset ignored");
	reset_selfclear_a: assert property (pointer_reset && !wr_control |=> !pointer_reset)
		else $error("pointer reset stuck");
	single_pin_a: assert property (queue_control[SINGLE_PIN_ROUTING_BIT]
		|=> !irq_out_secondary)
		else $error("secondary active in single pin routing");
	split_route_a: assert property (!queue_control[SINGLE_PIN_ROUTING_BIT]
		|=> irq_out_secondary == $past(|pending))
		else $error("secondary does not follow pending");
	// Checked at the register read so a broken gate anywhere on the path shows
	flag_gate_a: assert property (reg_rd && reg_addr == PENDING_FLAGS_ADDR
		&& !queue_control[FULL_IRQ_ALLOW_BIT] |=> !reg_rdata[FULL_PENDING_BIT])
		else $error("full flag without allow");
	level_read_a: assert property (reg_rd && reg_addr == WATERMARK_ADDR
		|=> reg_rdata[7:5] == 3'h0 && reg_rdata[4:0] == $past(watermark_level))
		else $error("watermark read wrong");
	pending_read_a: assert property (reg_rd && reg_addr == PENDING_FLAGS_ADDR
		|=> reg_rdata == {5'h00, $past(pending)})
		else $error("pending read wrong");

	fill_full_c: cover property (queue_full && queue_on);
	watermark_c: cover property (pending[WATERMARK_PENDING_BIT] && irq_out_secondary);
	drop_c: cover property (queue_control[WATERMARK_MODE_BIT] && at_level && sample_edge);
	combined_c: cover property (queue_control[SINGLE_PIN_ROUTING_BIT] && irq_out_primary);
endmodule : accel_sample_fifo_control

// ---- tb/sample_source.sv ----
// Model of the sample producer that drives the decimated sample clock pin
`timescale 1ns/1ps
module sample_source (
	input  wire logic sys_clk,    // Block clock
	output logic      sample_clk  // Sample clock pin, still between bursts
);
	initial sample_clk = 1'b0;
	// ------------------------------------------------------------
	// Burst of samples, one per 320 ns
	// ------------------------------------------------------------
	// High and low four block cycles each, well above the one-cycle minimum of the sync
	task automatic send(input int n);
		repeat (n) begin
			repeat (4) @(posedge sys_clk);
			#1 sample_clk = 1'b1;
			repeat (4) @(posedge sys_clk);
			#1 sample_clk = 1'b0;
		end
		repeat (4) @(posedge sys_clk);
	endtask : send
endmodule : sample_source

// ---- tb/accel_sample_fifo_control_bench.sv ----
// Self-checking bench of the sample queue control block
`timescale 1ns/1ps
module accel_sample_fifo_control_bench;
	import queue_ctrl_pkg::*;
	logic       sys_clk    = 1'b0;
	logic       rst        = 1'b1;
	logic [7:0] reg_addr   = 8'h00;
	logic [7:0] reg_wdata  = 8'h00;
	logic       reg_wr     = 1'b0;
	logic       reg_rd     = 1'b0;
	logic       sample_pop = 1'b0;
	logic       motion_req = 1'b0;
	logic       sample_clk;
	logic [7:0] reg_rdata;
	logic [4:0] wr_ptr;
	logic [4:0] rd_ptr;
	logic [5:0] sample_count;
	logic       irq_p;
	logic       irq_s;
	logic       sample_accept;
	int         n_accept   = 0;
	int         bad_count  = 0;
	int         n_tests    = 0;

	always #20 sys_clk = ~sys_clk;

	sample_source src (.sys_clk(sys_clk), .sample_clk(sample_clk));

	accel_sample_fifo_control DUT (
		.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sample_clk(sample_clk),
		.sample_pop(sample_pop), .motion_req(motion_req), .sample_accept(sample_accept),
		.wr_ptr(wr_ptr), .rd_ptr(rd_ptr), .sample_count(sample_count),
		.irq_out_primary(irq_p), .irq_out_secondary(irq_s));
	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		#1 reg_wr = 1'b1; reg_addr = a; reg_wdata = d;
		@(posedge sys_clk);
		#1 reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		#1 reg_rd = 1'b1; reg_addr = a;
		@(posedge sys_clk);
		#1 reg_rd = 1'b0;
		chk("reg_rdata", reg_rdata, exp);
	endtask : rd

	// Storage strobes are counted mid-cycle, where they stand settled
	always @(negedge sys_clk) begin
		if (sample_accept === 1'b1) n_accept++;
	end

	// Interrupt outputs lag the flags by a cycle, so give them room
	task automatic settle();
		repeat (4) @(posedge sys_clk);
		#1;
	endtask : settle

	task automatic wrap_up();
		if (bad_count == 0 && n_tests > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : wrap_up
	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (8) @(posedge sys_clk);
		#1 rst = 1'b0;
		rd(QUEUE_CONTROL_ADDR, 8'h00);
		rd(WATERMARK_ADDR, 8'h10);
		rd(PENDING_FLAGS_ADDR, 8'h00);
		rd(8'h30, 8'h00);
		wr(WATERMARK_ADDR, 8'h03);
		rd(WATERMARK_ADDR, 8'h03);
		wr(QUEUE_CONTROL_ADDR, 8'h07);
		src.send(1);
		rd(PENDING_FLAGS_ADDR, 8'h00);
		chk("count", {2'b00, sample_count}, 8'h00);
		wr(QUEUE_CONTROL_ADDR, 8'h27);
		rd(QUEUE_CONTROL_ADDR, 8'h27);
		settle();
		rd(PENDING_FLAGS_ADDR, 8'h01);
		chk("irq_s", {7'b0, irq_s}, 8'h01);
		chk("irq_p", {7'b0, irq_p}, 8'h00);
		motion_req = 1'b1;
		settle();
		chk("irq_p", {7'b0, irq_p}, 8'h01);
		motion_req = 1'b0;
		src.send(3);
		rd(PENDING_FLAGS_ADDR, 8'h04);
		wr(QUEUE_CONTROL_ADDR, 8'h2F);
		settle();
		chk("irq_p", {7'b0, irq_p}, 8'h01);
		chk("irq_s", {7'b0, irq_s}, 8'h00);
		wr(QUEUE_CONTROL_ADDR, 8'h65);
		src.send(2);
		chk("count", {2'b00, sample_count}, 8'h03);
		rd(PENDING_FLAGS_ADDR, 8'h04);
		wr(QUEUE_CONTROL_ADDR, 8'h23);
		rd(PENDING_FLAGS_ADDR, 8'h00);
		wr(QUEUE_CONTROL_ADDR, 8'h27);
		// One sample past full is offered and must be dropped
		src.send(30);
		chk("count", {2'b00, sample_count}, 8'h20);
		rd(PENDING_FLAGS_ADDR, 8'h06);
		// Queue is full here, so only the allow bit can hide the full flag
		wr(QUEUE_CONTROL_ADDR, 8'h25);
		rd(PENDING_FLAGS_ADDR, 8'h04);
		wr(QUEUE_CONTROL_ADDR, 8'h27);
		@(posedge sys_clk);
		#1 sample_pop = 1'b1;
		@(posedge sys_clk);
		#1 sample_pop = 1'b0;
		settle();
		chk("rd_ptr", {3'b000, rd_ptr}, 8'h01);
		chk("count", {2'b00, sample_count}, 8'h1F);
		src.send(1);
		chk("wr_ptr", {3'b000, wr_ptr}, 8'h01);
		// Three, then 29 up to full, then one more: every dropped sample gave no strobe
		chk("accepts", n_accept[7:0], 8'h21);
		wr(QUEUE_CONTROL_ADDR, 8'h37);
		settle();
		chk("wr_ptr", {3'b000, wr_ptr}, 8'h00);
		chk("rd_ptr", {3'b000, rd_ptr}, 8'h00);
		chk("count", {2'b00, sample_count}, 8'h00);
		rd(QUEUE_CONTROL_ADDR, 8'h27);
		rd(PENDING_FLAGS_ADDR, 8'h01);
		wrap_up();
	end

	// Tests take about 16 us; cut a hang well past that
	initial begin
		#100000;
		bad_count++;
		wrap_up();
	end
endmodule : accel_sample_fifo_control_bench
